/* design/pci_fe_pkg.sv */
// package: constants and types shared by the bus front end and its far-end agent
package pci_fe_pkg;
  localparam int ADDR_W = 32;
  localparam int CBE_W = 4;
  localparam int BYTE_W = 8;
  localparam int PERR_EN_BIT = 6;
  localparam logic [31:0] AD_RST = 32'h0000_0000;
  localparam logic [3:0] CBE_RST = 4'h0;
  localparam logic [15:0] CMD_REG_RST = 16'h0000;
  localparam logic [31:0] BE_ALL_OFF = 32'h0000_0000;

  typedef enum logic [1:0]
  {
    PH_IDLE = 2'b00,
    PH_ADDR = 2'b01,
    PH_DATA = 2'b10
  } phase_e;

  // even parity: par makes the count of ones across ad, cbe and par even
  function automatic logic even_par(input logic [31:0] ad, input logic [3:0] cbe);
    even_par = ^{ad, cbe};
  endfunction

  // expand byte enables to a per-bit mask, lane n governed by enable n
  function automatic logic [31:0] be_mask(input logic [3:0] be);
    logic [31:0] m;
    m = BE_ALL_OFF;
    for (int i = 0; i < CBE_W; i++)
    begin
      m[i*BYTE_W +: BYTE_W] = {BYTE_W{be[i]}};
    end
    be_mask = m;
  endfunction
endpackage

/* design/pci_fe_if.sv */
// interface: the shared bus lines between the device front end and the far agent
`timescale 1ns/1ps
`default_nettype none
interface pci_fe_if;
  logic [31:0] dev_ad_o;
  logic dev_ad_oe;
  logic [3:0] dev_cbe_o;
  logic dev_cbe_oe;
  logic dev_par_o;
  logic dev_par_oe;
  logic dev_perr_o;
  logic dev_perr_oe;
  logic [31:0] host_ad_o;
  logic host_ad_oe;
  logic [3:0] host_cbe_o;
  logic host_cbe_oe;
  logic host_par_o;
  logic host_par_oe;
  logic pci_bus_reset_in;
  logic [31:0] ad;
  logic [3:0] cbe;
  logic par;
  logic perr_n;

  // wired resolution; undriven lines read as pulled up
  assign ad = dev_ad_oe ? dev_ad_o : (host_ad_oe ? host_ad_o : 32'hFFFF_FFFF);
  assign cbe = dev_cbe_oe ? dev_cbe_o : (host_cbe_oe ? host_cbe_o : 4'hF);
  assign par = dev_par_oe ? dev_par_o : (host_par_oe ? host_par_o : 1'b1);
  assign perr_n = dev_perr_oe ? dev_perr_o : 1'b1;

  modport device
  (
    output dev_ad_o, dev_ad_oe, dev_cbe_o, dev_cbe_oe, dev_par_o, dev_par_oe,
    output dev_perr_o, dev_perr_oe,
    input ad, cbe, par, perr_n, pci_bus_reset_in
  );
  modport host
  (
    output host_ad_o, host_ad_oe, host_cbe_o, host_cbe_oe, host_par_o, host_par_oe,
    output pci_bus_reset_in,
    input ad, cbe, par, perr_n
  );
endinterface
`default_nettype wire

/* design/pci_fe_host.sv */
// module: far-end agent that initiates address and data phases toward the device
`timescale 1ns/1ps
`default_nettype none
module pci_fe_host
  import pci_fe_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  pci_fe_if.host bus,
  input wire logic bus_reset_req,
  input wire logic addr_start,
  input wire logic [31:0] addr_value,
  input wire logic [3:0] cmd_value,
  input wire logic data_start,
  input wire logic [31:0] data_value,
  input wire logic [3:0] be_value,
  input wire logic par_corrupt,
  output logic perr_seen
);
  import pci_fe_pkg::*;

  // ==========================================================
  // drive lines
  // ==========================================================
  logic [31:0] ad_ff;
  logic [3:0] cbe_ff;
  logic drive_ff;
  logic par_ff;
  logic par_oe_ff;
  logic perr_seen_ff;
  logic corrupt_ff;
  wire launch = addr_start | data_start;
  wire [31:0] nxt_ad = addr_start ? addr_value : data_value;
  wire [3:0] nxt_cbe = addr_start ? cmd_value : be_value;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ad_ff <= AD_RST;
      cbe_ff <= CBE_RST;
      drive_ff <= 1'b0;
      par_ff <= 1'b0;
      par_oe_ff <= 1'b0;
      corrupt_ff <= 1'b0;
      perr_seen_ff <= 1'b0;
    end
    else
    begin
      ad_ff <= nxt_ad;
      cbe_ff <= nxt_cbe;
      drive_ff <= launch;
      corrupt_ff <= par_corrupt;
      // parity follows its lines one clock later
      par_ff <= even_par(ad_ff, cbe_ff) ^ corrupt_ff;
      par_oe_ff <= drive_ff;
      perr_seen_ff <= ~bus.perr_n;
    end
  end

  assign bus.host_ad_o = ad_ff;
  assign bus.host_ad_oe = drive_ff;
  assign bus.host_cbe_o = cbe_ff;
  assign bus.host_cbe_oe = drive_ff;
  assign bus.host_par_o = par_ff;
  assign bus.host_par_oe = par_oe_ff;
  assign bus.pci_bus_reset_in = bus_reset_req;
  assign perr_seen = perr_seen_ff;
endmodule
`default_nettype wire

/* design/pci_fe_device.sv */
// module: device front end of the primary bus: reset, lane split, parity
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - sample all bus lines on rising clock
// - bus reset floats outputs, clears registers
// - no function during reset; default afterwards
// - reset with suspend floats outputs, keeps registers
// - address phase carries 32-bit address
// - data phase carries data word
// - address phase lanes give bus command
// - data phase lanes are byte enables
// - enable n governs byte lane n
// - even parity over ad and cbe
// - initiator drives parity one clock later
// - target flags parity mismatch as error
// - error driven only when command bit 6
module pci_fe_device
  import pci_fe_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  pci_fe_if.device bus,
  input wire logic suspend_req,
  input wire logic [15:0] cmd_reg_wdata,
  input wire logic cmd_reg_we,
  input wire logic addr_phase,
  input wire logic data_phase,
  input wire logic init_mode,
  input wire logic init_drive,
  input wire logic [31:0] init_ad,
  input wire logic [3:0] init_cbe,
  output logic [31:0] addr_out,
  output logic [3:0] cmd_out,
  output logic addr_valid,
  output logic [31:0] data_out,
  output logic [3:0] be_out,
  output logic data_valid,
  output logic parity_error,
  output logic [15:0] cmd_reg
);
  import pci_fe_pkg::*;

  // ==========================================================
  // reset qualification
  // ==========================================================
  // a bus reset alone clears state; with suspend the registers hold
  wire bus_rst = bus.pci_bus_reset_in;
  wire clear_now = bus_rst & ~suspend_req;
  wire hold_now = bus_rst & suspend_req;
  wire active = ~bus_rst;

  // ==========================================================
  // command register (parity-error enable lives here)
  // ==========================================================
  logic [15:0] cmd_reg_ff;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cmd_reg_ff <= CMD_REG_RST;
    end
    else if (clear_now)
    begin
      cmd_reg_ff <= CMD_REG_RST;
    end
    else if (active && cmd_reg_we)
    begin
      cmd_reg_ff <= cmd_reg_wdata;
    end
  end
  wire perr_en = cmd_reg_ff[PERR_EN_BIT];

  // ==========================================================
  // phase split of the multiplexed lanes
  // ==========================================================
  logic [31:0] addr_ff;
  logic [3:0] cmd_ff;
  logic addr_valid_ff;
  logic [31:0] data_ff;
  logic [3:0] be_ff;
  logic data_valid_ff;
  wire take_addr = active & addr_phase & ~init_mode;
  wire take_data = active & data_phase & ~init_mode;
  // lanes whose enable is off are zeroed so stale bytes never leak
  wire [31:0] data_masked = bus.ad & be_mask(bus.cbe);

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      addr_ff <= AD_RST;
      cmd_ff <= CBE_RST;
      data_ff <= AD_RST;
      be_ff <= CBE_RST;
    end
    else if (clear_now)
    begin
      addr_ff <= AD_RST;
      cmd_ff <= CBE_RST;
      data_ff <= AD_RST;
      be_ff <= CBE_RST;
    end
    else
    begin
      if (take_addr)
      begin
        addr_ff <= bus.ad;
        cmd_ff <= bus.cbe;
      end
      if (take_data)
      begin
        data_ff <= data_masked;
        be_ff <= bus.cbe;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      addr_valid_ff <= 1'b0;
      data_valid_ff <= 1'b0;
    end
    else
    begin
      addr_valid_ff <= take_addr;
      data_valid_ff <= take_data;
    end
  end

  // ==========================================================
  // initiator drive and delayed parity
  // ==========================================================
  logic [31:0] drv_ad_ff;
  logic [3:0] drv_cbe_ff;
  logic drv_oe_ff;
  logic par_out_ff;
  logic par_oe_ff;
  wire drive_go = active & init_mode & init_drive;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      drv_ad_ff <= AD_RST;
      drv_cbe_ff <= CBE_RST;
      drv_oe_ff <= 1'b0;
      par_out_ff <= 1'b0;
      par_oe_ff <= 1'b0;
    end
    else if (bus_rst)
    begin
      drv_oe_ff <= 1'b0;
      par_oe_ff <= 1'b0;
      if (clear_now)
      begin
        drv_ad_ff <= AD_RST;
        drv_cbe_ff <= CBE_RST;
        par_out_ff <= 1'b0;
      end
    end
    else
    begin
      drv_ad_ff <= init_ad;
      drv_cbe_ff <= init_cbe;
      drv_oe_ff <= drive_go;
      par_out_ff <= even_par(drv_ad_ff, drv_cbe_ff);
      par_oe_ff <= drv_oe_ff;
    end
  end

  // ==========================================================
  // target parity check
  // ==========================================================
  // parity arrives a clock after its lines, so the parity computed from the lines is held one clock
  logic chk_arm_ff;
  logic calc_par_ff;
  logic perr_ff;
  wire sampled_phase = take_addr | take_data;
  wire mismatch = chk_arm_ff & (calc_par_ff != bus.par);

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      chk_arm_ff <= 1'b0;
      calc_par_ff <= 1'b0;
      perr_ff <= 1'b0;
    end
    else if (bus_rst)
    begin
      chk_arm_ff <= 1'b0;
      perr_ff <= 1'b0;
      // a suspended reset leaves the held parity alone
      if (!hold_now)
      begin
        calc_par_ff <= 1'b0;
      end
    end
    else
    begin
      chk_arm_ff <= sampled_phase;
      calc_par_ff <= even_par(bus.ad, bus.cbe);
      perr_ff <= mismatch;
    end
  end

  // ==========================================================
  // outputs
  // ==========================================================
  assign bus.dev_ad_o = drv_ad_ff;
  assign bus.dev_ad_oe = drv_oe_ff & active;
  assign bus.dev_cbe_o = drv_cbe_ff;
  assign bus.dev_cbe_oe = drv_oe_ff & active;
  assign bus.dev_par_o = par_out_ff;
  assign bus.dev_par_oe = par_oe_ff & active;
  assign bus.dev_perr_o = 1'b0;
  assign bus.dev_perr_oe = perr_ff & perr_en & active;
  assign addr_out = addr_ff;
  assign cmd_out = cmd_ff;
  assign addr_valid = addr_valid_ff;
  assign data_out = data_ff;
  assign be_out = be_ff;
  assign data_valid = data_valid_ff;
  assign parity_error = perr_ff;
  assign cmd_reg = cmd_reg_ff;
endmodule
`default_nettype wire

/* dv/pci_fe_monitor.sv */
// checker: bus-level relations watched on the shared lines between both ends
`timescale 1ns/1ps
`default_nettype none
module pci_fe_monitor
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic pci_bus_reset_in,
  input wire logic dev_ad_oe,
  input wire logic dev_cbe_oe,
  input wire logic dev_par_oe,
  input wire logic dev_par_o,
  input wire logic dev_perr_oe,
  input wire logic dev_perr_o,
  input wire logic [31:0] ad,
  input wire logic [3:0] cbe,
  input wire logic par,
  input wire logic perr_n
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!resetn);
  // ==================================================
  // assertions
  a_reset_floats_outputs: assert property (pci_bus_reset_in |-> !dev_ad_oe && !dev_perr_oe)
    else $error("device drives in bus reset");
  a_reset_floats_par: assert property (pci_bus_reset_in |-> !dev_cbe_oe && !dev_par_oe)
    else $error("device drives cbe or par in bus reset");
  a_default_after_reset: assert property ($fell(pci_bus_reset_in) |-> !dev_ad_oe && !dev_par_oe)
    else $error("device active on leaving bus reset");
  a_cmd_with_addr: assert property (dev_ad_oe == dev_cbe_oe)
    else $error("ad and cbe not driven together");
  a_par_follows_word: assert property ($past(dev_ad_oe) && !pci_bus_reset_in |-> dev_par_oe)
    else $error("parity missing one clock after word");
  a_par_needs_word: assert property (dev_par_oe |-> $past(dev_ad_oe))
    else $error("parity driven without preceding word");
  a_par_even_value: assert property (dev_par_oe |-> dev_par_o == ^{$past(ad), $past(cbe)})
    else $error("driven parity not even");
  a_perr_on_mismatch: assert property (dev_perr_oe |-> $past(par) != ^{$past(ad, 2), $past(cbe, 2)})
    else $error("parity error without mismatch");
  a_perr_drives_low: assert property (dev_perr_oe |-> !dev_perr_o && !perr_n)
    else $error("parity error line not low");
  c_perr: cover property (dev_perr_oe);
  c_back_to_back: cover property (dev_ad_oe ##1 dev_ad_oe);
  c_reset_exit: cover property ($fell(pci_bus_reset_in));
endmodule
`default_nettype wire

/* dv/pci_primary_bus_front_end_tb.sv */
// testbench: device front end and far agent joined, target, initiator and reset cases
`timescale 1ns/1ps
`default_nettype none
module pci_primary_bus_front_end_tb;
  import pci_fe_pkg::*;
  logic clk, resetn, suspend_req, cmd_reg_we, addr_phase, data_phase, init_mode, init_drive;
  logic bus_reset_req, addr_start, data_start, par_corrupt, addr_valid, data_valid;
  logic parity_error, perr_seen, en;
  logic [15:0] cmd_reg_wdata, cmd_reg;
  logic [31:0] init_ad, addr_value, data_value, addr_out, data_out;
  logic [3:0] init_cbe, cmd_value, be_value, cmd_out, be_out;
  int failures = 0;
  int checks_done = 0;
  // {corrupt, lanes, word}; every single lane, all and none
  logic [36:0] rows [6] = '{37'h0_1_1234_5678, 37'h1_2_89AB_CDEF, 37'h0_4_FFFF_0000,
    37'h1_8_0F0F_F0F0, 37'h0_F_A5C3_3C5A, 37'h0_0_7777_7777};
  pci_fe_if bus ();
  pci_fe_device u_pci_fe_device (.clk, .resetn, .bus(bus.device), .suspend_req,
    .cmd_reg_wdata, .cmd_reg_we, .addr_phase, .data_phase, .init_mode, .init_drive,
    .init_ad, .init_cbe, .addr_out, .cmd_out, .addr_valid, .data_out, .be_out,
    .data_valid, .parity_error, .cmd_reg);
  pci_fe_host u_pci_fe_host (.clk, .resetn, .bus(bus.host), .bus_reset_req, .addr_start,
    .addr_value, .cmd_value, .data_start, .data_value, .be_value, .par_corrupt, .perr_seen);
  pci_fe_monitor u_pci_fe_monitor (.clk, .resetn, .pci_bus_reset_in(bus.pci_bus_reset_in),
    .dev_ad_oe(bus.dev_ad_oe), .dev_cbe_oe(bus.dev_cbe_oe), .dev_par_oe(bus.dev_par_oe),
    .dev_par_o(bus.dev_par_o), .dev_perr_oe(bus.dev_perr_oe), .dev_perr_o(bus.dev_perr_o),
    .ad(bus.ad), .cbe(bus.cbe), .par(bus.par), .perr_n(bus.perr_n));

  initial
  begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input logic [36:0] seen, input logic [36:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    if (failures == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  function automatic logic [31:0] lanes(input logic [31:0] d, input logic [3:0] l);
    lanes = {{8{l[3]}}, {8{l[2]}}, {8{l[1]}}, {8{l[0]}}} & d;
  endfunction

  // one target phase launched by the far agent, captured, then parity judged
  task automatic xfer(input logic dp, input logic [31:0] d, input logic [3:0] l, input logic bad);
    @(posedge clk);
    addr_start <= !dp;
    data_start <= dp;
    {addr_value, data_value, cmd_value, be_value} <= {d, d, l, l};
    par_corrupt <= bad;
    @(posedge clk);
    {addr_start, data_start, par_corrupt} <= 3'h0;
    addr_phase <= !dp;
    data_phase <= dp;
    @(posedge clk);
    {addr_phase, data_phase} <= 2'h0;
    @(negedge clk);
    if (dp)
      chk({data_valid, be_out, data_out}, {1'b1, l, lanes(d, l)});
    else
      chk({addr_valid, cmd_out, addr_out}, {1'b1, l, d});
    @(negedge clk);
    chk(37'(parity_error), 37'(bad));
    @(negedge clk);
    chk(37'(perr_seen), 37'(bad & en));
  endtask

  task automatic wr_cmd(input logic [15:0] v);
    @(posedge clk);
    cmd_reg_wdata <= v;
    cmd_reg_we <= 1;
    @(posedge clk);
    cmd_reg_we <= 0;
    @(negedge clk);
  endtask

  // ==================================================
  // main sequence
  initial
  begin
    {suspend_req, cmd_reg_we, addr_phase, data_phase, init_mode, init_drive} = '0;
    {bus_reset_req, addr_start, data_start, par_corrupt, en} = '0;
    {cmd_reg_wdata, init_ad, init_cbe, addr_value, data_value, cmd_value, be_value} = '0;
    resetn = 0;
    repeat (20) @(posedge clk);
    resetn <= 1;
    @(negedge clk);
    chk(37'(cmd_reg), 37'(CMD_REG_RST));
    wr_cmd(16'h0040);
    en = 1;
    foreach (rows[i])
    begin
      xfer(0, rows[i][31:0], rows[i][35:32], rows[i][36]);
      xfer(1, ~rows[i][31:0], rows[i][35:32], !rows[i][36]);
    end
    // initiator, two words back to back so parity must pipeline
    @(posedge clk);
    {init_mode, init_drive, init_ad, init_cbe} <= {2'h3, 32'hA5A5_0F0F, 4'h6};
    @(posedge clk);
    {init_ad, init_cbe} <= {32'h1357_9BDF, 4'hB};
    @(negedge clk);
    chk(37'({bus.cbe, bus.ad}), {5'h06, 32'hA5A5_0F0F});
    @(posedge clk);
    init_drive <= 0;
    @(negedge clk);
    chk({bus.par, bus.cbe, bus.ad}, {^{32'hA5A5_0F0F, 4'h6}, 4'hB, 32'h1357_9BDF});
    @(negedge clk);
    chk(37'(bus.par), 37'(^{32'h1357_9BDF, 4'hB}));
    // reset with suspend: refuses capture and writes, keeps registers
    @(posedge clk);
    init_mode <= 0;
    {suspend_req, bus_reset_req, addr_phase} <= 3'h7;
    repeat (3) @(posedge clk);
    addr_phase <= 0;
    @(negedge clk);
    chk(37'(addr_valid), 37'h0);
    wr_cmd(16'h0000);
    chk(37'(cmd_reg), 37'h40);
    chk(37'(addr_out), 37'(rows[5][31:0]));
    @(posedge clk);
    suspend_req <= 0;
    repeat (2) @(posedge clk);
    bus_reset_req <= 0;
    @(negedge clk);
    chk(37'(cmd_reg), 37'(CMD_REG_RST));
    chk(37'(addr_out), 37'(AD_RST));
    en = 0;
    xfer(0, 32'hDEAD_BEEF, 4'h7, 1);
    summarize();
  end

  initial
  begin
    repeat (3000) @(posedge clk);
    failures++;
    summarize();
  end
endmodule
`default_nettype wire
